// ---- srb_regs.sv ----
// Upper register group of a dual-path synthesizer: calibration extras,
// internal outputs, identification, readback and test controls.
// Assumes status inputs come from logic on i_clk; serial pins are asynchronous.
//
// What this block does
// - Lock bit reads 0 locked, 1 unlocked
// - Coarse readback: result if enabled, else default
// - Pump readback: result if gain cal enabled
// - Capture tuning voltage at gain cal start
// - Capture tuning voltage at gain cal end
// - Radio state machine readable at top bits
// - Test bits force pump up or down, only while test enable is set
// - Modulator disable makes divider integer only
// - Test enable and test mux select
// - Internal outputs follow the active path
// - Path 2 coarse voltage, resets to 16
// - Fixed part and revision identification word
// - Enable 11 means on, 00 off
`timescale 1ns/1ps
`include "srb_defines.svh"
module srb_regs import srb_pkg::*; #(
    parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] REV_ID = 8'h01, // Arbitrary value
    parameter int CT_W = 7,
    parameter int CP_W = 6,
    parameter int VOLT_W = 8,
    parameter int STATE_W = 6
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial pins
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_ser_sel_n,
    output logic o_ser_data,
    output logic o_ser_data_oe,
    // Path selection and calibration settings from the lower registers
    input wire logic i_path2_active,
    input wire logic [1:0] i_p1_coarse_tune_enable,
    input wire logic [1:0] i_p2_coarse_tune_enable,
    input wire logic [1:0] i_p1_tuning_gain_cal_enable,
    input wire logic [1:0] i_p2_tuning_gain_cal_enable,
    input wire logic [CT_W-1:0] i_p1_coarse_tune_default,
    input wire logic [CT_W-1:0] i_p2_coarse_tune_default,
    input wire logic [CP_W-1:0] i_p1_pump_current_default,
    input wire logic [CP_W-1:0] i_p2_pump_current_default,
    // Calibration engine and loop status
    input wire logic i_loop_locked,
    input wire logic [CT_W-1:0] i_coarse_tune_result,
    input wire logic [CP_W-1:0] i_pump_current_result,
    input wire logic i_gain_cal_start,
    input wire logic i_gain_cal_end,
    input wire logic [VOLT_W-1:0] i_tune_voltage,
    input wire logic [STATE_W-1:0] i_radio_fsm_state,
    // Calibration extras
    output logic [10:0] o_path2_phase_adjust,
    output logic [4:0] o_path2_coarse_cal_voltage,
    // Internal control outputs 1, 3, 4
    output logic [2:0] o_internal_out,
    // Test controls
    output logic o_test_operation_enable,
    output logic [2:0] o_test_mux_select,
    output logic o_force_pump_up,
    output logic o_force_pump_down,
    output logic o_modulator_disable,
    output logic o_regulator_bypass,
    output logic o_dac_test
);
    // ----------------------------------------
    // Serial access
    // ----------------------------------------
    logic [6:0] addr; // Frame address
    logic wr; // One-cycle write strobe
    logic [15:0] wdata;
    logic [15:0] rdata; // Read mux into serial shifter

    srb_serial_port u_port (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ser_clk(i_ser_clk),
        .i_ser_data(i_ser_data),
        .i_ser_sel_n(i_ser_sel_n),
        .o_ser_data(o_ser_data),
        .o_ser_data_oe(o_ser_data_oe),
        .o_addr(addr),
        .o_wr(wr),
        .o_wdata(wdata),
        .i_rdata(rdata)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [15:0] cal_extra_ff; // Phase adjust and coarse voltage
    logic [15:0] gpo_ff; // Per-path internal output settings
    logic [15:0] test_ff; // Test mode controls

    // Writable registers hold until rewritten; unused bits stay zero, except test bits 7:5, which are stored and read back
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cal_extra_ff <= `SRB_CAL_EXTRA_RST;
            gpo_ff <= `SRB_GPO_RST;
            test_ff <= `SRB_TEST_RST;
        end else if (wr) begin
            case (addr)
                `SRB_OFF_CAL_EXTRA: cal_extra_ff <= wdata;
                `SRB_OFF_GPO: gpo_ff <= wdata & `SRB_GPO_WMASK;
                `SRB_OFF_TEST: test_ff <= wdata & `SRB_TEST_WMASK;
                default: ; // Readback and unmapped: write dropped
            endcase
        end
    end

    assign o_path2_phase_adjust = cal_extra_ff[15:5];
    assign o_path2_coarse_cal_voltage = cal_extra_ff[`SRB_CT_V_MSB:0];

    // ----------------------------------------
    // Test outputs
    // ----------------------------------------
    // Pump forcing only acts in test operation so a stray bit cannot
    // drag the loop off lock in normal use
    assign o_test_operation_enable = test_ff[`SRB_TEN_BIT];
    assign o_test_mux_select = test_ff[`SRB_TEST_MUX_SELECT_MSB:`SRB_TEST_MUX_SELECT_LSB];
    assign o_force_pump_up = test_ff[`SRB_TEN_BIT] & test_ff[`SRB_PUMP_UP_BIT];
    assign o_force_pump_down = test_ff[`SRB_TEN_BIT] & test_ff[`SRB_PUMP_DN_BIT];
    assign o_modulator_disable = test_ff[`SRB_MOD_DIS_BIT];
    assign o_regulator_bypass = test_ff[`SRB_LDO_BYP_BIT];
    assign o_dac_test = test_ff[`SRB_DAC_TEST_BIT];

    // ----------------------------------------
    // Internal outputs per active path
    // ----------------------------------------
    localparam logic [3:0] GPO_P1_POS [3] = '{4'd14, 4'd12, 4'd11};
    logic [2:0] int_out_ff;

    // Path 2 copy of each setting sits a fixed gap below path 1
    for (genvar k = 0; k < 3; k++) begin : g_int_out
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                int_out_ff[k] <= 1'b0;
            end else if (i_path2_active) begin
                int_out_ff[k] <= gpo_ff[GPO_P1_POS[k] - `SRB_GPO_PATH_GAP];
            end else begin
                int_out_ff[k] <= gpo_ff[GPO_P1_POS[k]];
            end
        end
    end
    assign o_internal_out = int_out_ff;

    // ----------------------------------------
    // Gain calibration voltage capture
    // ----------------------------------------
    logic [VOLT_W-1:0] vstart_ff; // Voltage at calibration start
    logic [VOLT_W-1:0] vend_ff; // Voltage at calibration end

    // Each capture holds until the next calibration overwrites it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            vstart_ff <= '0;
            vend_ff <= '0;
        end else begin
            if (i_gain_cal_start) begin
                vstart_ff <= i_tune_voltage;
            end
            if (i_gain_cal_end) begin
                vend_ff <= i_tune_voltage;
            end
        end
    end

    // ----------------------------------------
    // Readback selection
    // ----------------------------------------
    logic ct_on; // Active path coarse tune enabled
    logic kv_on; // Active path gain calibration enabled
    logic [CT_W-1:0] ct_rb;
    logic [CP_W-1:0] cp_rb;

    // Only the 11 code enables; any other code falls back to the default
    assign ct_on = (i_path2_active ? i_p2_coarse_tune_enable
        : i_p1_coarse_tune_enable) == `SRB_CAL_ENABLED;
    assign kv_on = (i_path2_active ? i_p2_tuning_gain_cal_enable
        : i_p1_tuning_gain_cal_enable) == `SRB_CAL_ENABLED;
    assign ct_rb = ct_on ? i_coarse_tune_result
        : (i_path2_active ? i_p2_coarse_tune_default : i_p1_coarse_tune_default);
    assign cp_rb = kv_on ? i_pump_current_result
        : (i_path2_active ? i_p2_pump_current_default : i_p1_pump_current_default);

    // Combinational mux; the serial port latches it once the header ends
    always_comb begin
        rdata = 16'h0000;
        case (addr)
            `SRB_OFF_CAL_EXTRA: rdata = cal_extra_ff;
            `SRB_OFF_GPO: rdata = gpo_ff;
            `SRB_OFF_CHIP_ID: rdata = {PART_ID, REV_ID};
            `SRB_OFF_RB_LOCK: rdata = {~i_loop_locked, ct_rb, cp_rb, 2'b00};
            `SRB_OFF_RB_GAIN: rdata = {vstart_ff, vend_ff};
            `SRB_OFF_RB_STATE: rdata = {i_radio_fsm_state, 10'h000};
            `SRB_OFF_TEST: rdata = test_ff;
            default: rdata = 16'h0000; // Unmapped reads as zero
        endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence test_write_s;
        wr && addr == `SRB_OFF_TEST;
    endsequence
    sequence gain_write_s;
        wr && addr == `SRB_OFF_RB_GAIN && !i_gain_cal_start && !i_gain_cal_end;
    endsequence

    lock_bit_a: assert property (
        addr == `SRB_OFF_RB_LOCK |-> rdata[`SRB_LOCK_BIT] != i_loop_locked)
        else $error("lock bit polarity wrong");
    coarse_pick_a: assert property (
        addr == `SRB_OFF_RB_LOCK && !i_path2_active && i_p1_coarse_tune_enable == 2'b00
        |-> rdata[14:8] == i_p1_coarse_tune_default) else $error("coarse default not shown");
    coarse_result_a: assert property (
        addr == `SRB_OFF_RB_LOCK && i_path2_active && i_p2_coarse_tune_enable == 2'b11
        |-> rdata[14:8] == i_coarse_tune_result) else $error("coarse result not shown");
    pump_pick_a: assert property (
        addr == `SRB_OFF_RB_LOCK && !i_path2_active && i_p1_tuning_gain_cal_enable == 2'b11
        |-> rdata[7:2] == i_pump_current_result) else $error("pump result not shown");
    start_volt_a: assert property (
        i_gain_cal_start |=> (vstart_ff == $past(i_tune_voltage)) [*1] ##1
        (addr != `SRB_OFF_RB_GAIN || $past(i_gain_cal_start)
        || rdata[15:8] == $past(i_tune_voltage, 2)))
        else $error("start voltage not captured");
    end_volt_a: assert property (
        i_gain_cal_end ##1 (addr == `SRB_OFF_RB_GAIN && !i_gain_cal_end)
        |-> rdata[7:0] == $past(i_tune_voltage)) else $error("end voltage not captured");
    state_rb_a: assert property (
        addr == `SRB_OFF_RB_STATE |-> rdata == {i_radio_fsm_state, 10'h000})
        else $error("state readback wrong");
    pump_force_a: assert property (
        test_write_s |=> o_force_pump_up == ($past(wdata[15]) && $past(wdata[11]))
        && o_force_pump_down == ($past(wdata[15]) && $past(wdata[10])))
        else $error("pump force mismatch");
    mod_disable_a: assert property (
        test_write_s |=> o_modulator_disable == $past(wdata[9]))
        else $error("modulator disable not applied");
    test_mux_a: assert property (
        test_write_s |=> o_test_mux_select == $past(wdata[14:12])
        && o_test_operation_enable == $past(wdata[15])) else $error("test controls wrong");
    int_out_a: assert property (
        i_path2_active && $stable(gpo_ff) ##1 i_path2_active
        |-> o_internal_out[0] == $past(gpo_ff[6])) else $error("path 2 output not selected");
    ct_v_reset_a: assert property (
        $rose(i_rst_n) |-> o_path2_coarse_cal_voltage == 5'd16 && o_path2_phase_adjust == '0)
        else $error("coarse voltage reset wrong");
    chip_id_a: assert property (
        wr && addr == `SRB_OFF_CHIP_ID ##1 addr == `SRB_OFF_CHIP_ID
        |-> rdata == {PART_ID, REV_ID}) else $error("identification changed");
    ro_ignore_a: assert property (
        gain_write_s |=> $stable(vstart_ff) && $stable(vend_ff))
        else $error("readback altered by write");
endmodule : srb_regs

// ---- srb_defines.svh ----
// Offsets, field positions, reset values and timing for the readback/test bank.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SRB_DEFINES_SVH
`define SRB_DEFINES_SVH

// ----------------------------------------
// Register offsets (7-bit serial address)
// ----------------------------------------
`define SRB_OFF_CAL_EXTRA 7'h15
`define SRB_OFF_GPO 7'h18
`define SRB_OFF_CHIP_ID 7'h19
`define SRB_OFF_RB_LOCK 7'h1c
`define SRB_OFF_RB_GAIN 7'h1d
`define SRB_OFF_RB_STATE 7'h1e
`define SRB_OFF_TEST 7'h1f

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define SRB_CAL_EXTRA_RST 16'h0010
`define SRB_CT_V_RST 5'h10
`define SRB_GPO_RST 16'h0000
`define SRB_GPO_WMASK 16'h5858
`define SRB_TEST_RST 16'h0000
`define SRB_TEST_WMASK 16'hfff0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRB_LOCK_BIT 15
`define SRB_CT_MSB 14
`define SRB_CT_LSB 8
`define SRB_CP_MSB 7
`define SRB_CP_LSB 2
`define SRB_STATE_LSB 10
`define SRB_TEN_BIT 15
`define SRB_TEST_MUX_SELECT_MSB 14
`define SRB_TEST_MUX_SELECT_LSB 12
`define SRB_PUMP_UP_BIT 11
`define SRB_PUMP_DN_BIT 10
`define SRB_MOD_DIS_BIT 9
`define SRB_LDO_BYP_BIT 8
`define SRB_DAC_TEST_BIT 4
`define SRB_CT_V_MSB 4
`define SRB_GPO_PATH_GAP 8

// ----------------------------------------
// Serial frame timing (sclk edges) and calibration enable code
// ----------------------------------------
`define SRB_HEAD_LAST 5'd7
`define SRB_DATA_LAST 5'd23
`define SRB_FRAME_BITS 5'd24
`define SRB_CAL_ENABLED 2'b11

`endif

// ---- srb_pkg.sv ----
// Types shared by the readback/test register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package srb_pkg;
    // Serial port frame phase, one-hot
    typedef enum logic [2:0] {
        SRB_IDLE = 3'b001,
        SRB_HEAD = 3'b010,
        SRB_DATA = 3'b100
    } srb_port_e;
endpackage : srb_pkg

// ---- srb_serial_port.sv ----
// Three-wire serial slave: R/W bit, 7-bit address, 16 data bits, MSB first.
// Assumes pins are asynchronous and sclk phases last at least 4 i_clk cycles.
`timescale 1ns/1ps
`include "srb_defines.svh"
module srb_serial_port import srb_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial pins
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_ser_sel_n,
    output logic o_ser_data,
    output logic o_ser_data_oe,
    // Register side
    output logic [6:0] o_addr,
    output logic o_wr,
    output logic [15:0] o_wdata,
    input wire logic [15:0] i_rdata
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sclk_sy_ff; // Stage 0 feeds stage 1 only
    logic [1:0] sdat_sy_ff;
    logic [1:0] sel_sy_ff;
    logic sclk_d_ff; // Previous synced sclk for edges
    logic rise;
    logic fall;
    logic framed;

    // Two flops per pin before any logic looks at it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sclk_sy_ff <= 2'h0;
            sdat_sy_ff <= 2'h0;
            sel_sy_ff <= 2'h3;
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_sy_ff <= {sclk_sy_ff[0], i_ser_clk};
            sdat_sy_ff <= {sdat_sy_ff[0], i_ser_data};
            sel_sy_ff <= {sel_sy_ff[0], i_ser_sel_n};
            sclk_d_ff <= sclk_sy_ff[1];
        end
    end

    assign rise = sclk_sy_ff[1] & ~sclk_d_ff;
    assign fall = ~sclk_sy_ff[1] & sclk_d_ff;
    assign framed = ~sel_sy_ff[1];

    // ----------------------------------------
    // Frame sequencing
    // ----------------------------------------
    srb_port_e state_ff;
    logic [4:0] cnt_ff; // Rising sclk edges seen in frame
    logic [7:0] head_ff; // R/W bit then address
    logic [15:0] data_ff; // Shared write/read shifter
    logic load_ff; // Header just completed
    logic oe_ff;
    logic wr_ff;

    // Phase tracking; deselect aborts anywhere
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !framed) begin
            state_ff <= SRB_IDLE;
        end else begin
            case (state_ff)
                SRB_IDLE: state_ff <= SRB_HEAD;
                SRB_HEAD: begin
                    if (rise && cnt_ff == `SRB_HEAD_LAST) begin
                        state_ff <= SRB_DATA;
                    end
                end
                SRB_DATA: state_ff <= SRB_DATA;
                default: state_ff <= SRB_IDLE;
            endcase
        end
    end

    // Edge counter saturates so extra clocks do nothing
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || state_ff == SRB_IDLE) begin
            cnt_ff <= 5'h0;
        end else if (rise && cnt_ff != `SRB_FRAME_BITS) begin
            cnt_ff <= cnt_ff + 5'h1;
        end
    end

    // Header capture
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            head_ff <= 8'h0;
            load_ff <= 1'b0;
        end else begin
            load_ff <= (state_ff == SRB_HEAD) && rise && (cnt_ff == `SRB_HEAD_LAST);
            if (state_ff == SRB_HEAD && rise) begin
                head_ff <= {head_ff[6:0], sdat_sy_ff[1]};
            end
        end
    end

    // Data shifter: shift in on rise for writes, shift out on fall for reads.
    // The fall right after the header is skipped so bit 15 meets the 9th rise.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            data_ff <= 16'h0;
        end else if (load_ff && head_ff[7]) begin
            data_ff <= i_rdata;
        end else if (state_ff == SRB_DATA && !head_ff[7] && rise) begin
            data_ff <= {data_ff[14:0], sdat_sy_ff[1]};
        end else if (state_ff == SRB_DATA && head_ff[7] && fall && cnt_ff > 5'd8) begin
            data_ff <= {data_ff[14:0], 1'b0};
        end
    end

    // Drive enable and write strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !framed) begin
            oe_ff <= 1'b0;
            wr_ff <= 1'b0;
        end else begin
            if (load_ff && head_ff[7]) begin
                oe_ff <= 1'b1;
            end
            wr_ff <= (state_ff == SRB_DATA) && !head_ff[7] && rise
                && (cnt_ff == `SRB_DATA_LAST);
        end
    end

    assign o_ser_data = data_ff[15];
    assign o_ser_data_oe = oe_ff;
    assign o_addr = head_ff[6:0];
    assign o_wr = wr_ff;
    assign o_wdata = data_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    wr_single_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_wr |=> !o_wr) else $error("write strobe longer than one cycle");
    oe_framed_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_ser_data_oe |-> head_ff[7] && $past(framed)) else $error("drive outside read frame");
endmodule : srb_serial_port

// ---- srb_host.sv ----
// Host controller model: sends three-wire frames to the register bank.
// Assumes i_clk is the bank clock; sclk, select and driven data change on its falling edge, the released-pin pattern on its rising edge.
`timescale 1ns/1ps
module srb_host (
    // Clock
    input wire logic i_clk,
    // Device side of the shared data pin
    input wire logic i_dev_data,
    input wire logic i_dev_oe,
    // Pins
    output logic o_ser_clk,
    output logic o_ser_sel_n,
    output logic o_pin
);
    logic drv = 1'b0; // Host owns the data pin
    logic hd = 1'b0; // Host data bit
    logic flt = 1'b0; // Pattern on a released pin
    initial begin
        o_ser_clk = 1'b0;
        o_ser_sel_n = 1'b1;
    end
    // Released pin toggles so a stale bit never reads back as valid
    always @(posedge i_clk) flt <= ~flt;
    // Wire level from both parties' enables
    assign o_pin = i_dev_oe ? i_dev_data : (drv ? hd : flt);
    // Six-clock phases keep clear of the four-clock minimum
    task automatic ph();
        repeat (6) @(negedge i_clk);
    endtask : ph
    // One frame: R/W, address, one 16-bit word, MSB first
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                        output logic [15:0] q);
        logic [23:0] sh;
        sh = {rd, a, wd};
        q = 16'h0;
        @(negedge i_clk);
        o_ser_sel_n = 1'b0;
        ph();
        for (int i = 23; i >= 0; i--) begin
            drv = !(rd && i < 16); // Let go of the pin for read data
            hd = sh[i];
            ph();
            o_ser_clk = 1'b1;
            if (i < 16) q[i] = o_pin;
            ph();
            o_ser_clk = 1'b0;
        end
        drv = 1'b0;
        ph();
        o_ser_sel_n = 1'b1;
        ph();
    endtask : xfer
endmodule : srb_host

// ---- testbench.sv ----
// Self-checking bench for the readback and test register bank.
// Assumes srb_host as the serial master; status inputs are driven here.
`timescale 1ns/1ps
`include "srb_defines.svh"
module testbench;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic ser_clk, ser_sel_n, pin, dev_d, dev_oe;
    logic p2 = 1'b0;
    logic [1:0] ce1 = 2'h0, ce2 = 2'h0, ke1 = 2'h0, ke2 = 2'h0;
    logic [6:0] ctd1 = 7'h0, ctd2 = 7'h0, ctr = 7'h0;
    logic [5:0] cpd1 = 6'h0, cpd2 = 6'h0, cpr = 6'h0, st = 6'h0;
    logic lk = 1'b0, gs = 1'b0, ge = 1'b0;
    logic [7:0] tv = 8'h0, va;
    logic [10:0] phs;
    logic [4:0] ctv;
    logic [2:0] io, mux;
    logic test_operation_enable, pu, pd, md, lb, dt;
    logic [15:0] q, w;
    int num_errors = 0;
    int cmp_count = 0;
    // ----------------------------------------
    // Clock, host and design
    // ----------------------------------------
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    srb_host host (.i_clk(i_clk), .i_dev_data(dev_d), .i_dev_oe(dev_oe),
        .o_ser_clk(ser_clk), .o_ser_sel_n(ser_sel_n), .o_pin(pin));
    srb_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ser_clk(ser_clk),
        .i_ser_data(pin), .i_ser_sel_n(ser_sel_n), .o_ser_data(dev_d),
        .o_ser_data_oe(dev_oe), .i_path2_active(p2),
        .i_p1_coarse_tune_enable(ce1), .i_p2_coarse_tune_enable(ce2),
        .i_p1_tuning_gain_cal_enable(ke1), .i_p2_tuning_gain_cal_enable(ke2),
        .i_p1_coarse_tune_default(ctd1), .i_p2_coarse_tune_default(ctd2),
        .i_p1_pump_current_default(cpd1), .i_p2_pump_current_default(cpd2),
        .i_loop_locked(lk), .i_coarse_tune_result(ctr), .i_pump_current_result(cpr),
        .i_gain_cal_start(gs), .i_gain_cal_end(ge), .i_tune_voltage(tv),
        .i_radio_fsm_state(st), .o_path2_phase_adjust(phs),
        .o_path2_coarse_cal_voltage(ctv), .o_internal_out(io),
        .o_test_operation_enable(test_operation_enable), .o_test_mux_select(mux),
        .o_force_pump_up(pu), .o_force_pump_down(pd), .o_modulator_disable(md),
        .o_regulator_bypass(lb), .o_dac_test(dt));
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        host.xfer(1'b1, a, 16'h0, q);
        chk(q, exp);
    endtask : rd
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.xfer(1'b0, a, d, q);
    endtask : wr
    // Lock, coarse and pump readback for the active path
    function automatic logic [15:0] exp_rb1();
        logic [1:0] ce;
        logic [1:0] ke;
        ce = p2 ? ce2 : ce1;
        ke = p2 ? ke2 : ke1;
        return {!lk, (ce == `SRB_CAL_ENABLED) ? ctr : (p2 ? ctd2 : ctd1),
                (ke == `SRB_CAL_ENABLED) ? cpr : (p2 ? cpd2 : cpd1), 2'b00};
    endfunction : exp_rb1
    // Test outputs; pump forcing only counts with test enable
    function automatic logic [15:0] exp_tst(input logic [15:0] v);
        return {7'h0, v[15], v[14:12], v[15] & v[11], v[15] & v[10], v[9], v[8], v[4]};
    endfunction : exp_tst
    task automatic wrap_up();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // Hang guard
    initial begin
        repeat (90000) @(posedge i_clk);
        num_errors++;
        wrap_up();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(88));
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        chk({11'h0, ctv}, 16'h0010);
        rd(`SRB_OFF_CAL_EXTRA, `SRB_CAL_EXTRA_RST);
        rd(`SRB_OFF_CHIP_ID, 16'h5a01);
        wr(`SRB_OFF_CHIP_ID, 16'hffff);
        rd(`SRB_OFF_CHIP_ID, 16'h5a01);
        wr(7'h03, 16'hffff);
        rd(7'h03, 16'h0000);
        // Control words: both forces, forces without enable, then random
        for (int k = 0; k < 8; k++) begin
            w = (k == 0) ? 16'h8c00 : (k == 1) ? 16'h7fff : 16'($urandom);
            wr(`SRB_OFF_TEST, w);
            rd(`SRB_OFF_TEST, w & `SRB_TEST_WMASK);
            chk({7'h0, test_operation_enable, mux, pu, pd, md, lb, dt}, exp_tst(w));
            wr(`SRB_OFF_CAL_EXTRA, ~w);
            rd(`SRB_OFF_CAL_EXTRA, ~w);
            chk({phs, ctv}, ~w);
            wr(`SRB_OFF_GPO, w);
            rd(`SRB_OFF_GPO, w & `SRB_GPO_WMASK);
            for (int p = 0; p < 2; p++) begin
                p2 = p[0];
                repeat (2) @(negedge i_clk);
                chk({13'h0, io}, p2 ? {13'h0, w[3], w[4], w[6]}
                                    : {13'h0, w[11], w[12], w[14]});
            end
        end
        // Every enable code, set on both paths, read on a random path with random status
        for (int k = 0; k < 16; k++) begin
            {p2, lk, ctd1, ctd2, ctr} = 23'($urandom);
            {cpd1, cpd2, cpr, st} = 24'($urandom);
            ce1 = k[1:0];
            ce2 = k[1:0];
            ke1 = k[3:2];
            ke2 = k[3:2];
            rd(`SRB_OFF_RB_LOCK, exp_rb1());
            rd(`SRB_OFF_RB_STATE, {st, 10'h0});
        end
        // Gain calibration captures at start and end pulses
        for (int k = 0; k < 3; k++) begin
            va = 8'($urandom);
            w[7:0] = 8'($urandom);
            tv = va;
            gs = 1'b1;
            @(negedge i_clk);
            gs = 1'b0;
            tv = w[7:0];
            ge = 1'b1;
            @(negedge i_clk);
            ge = 1'b0;
            tv = ~w[7:0];
            rd(`SRB_OFF_RB_GAIN, {va, w[7:0]});
        end
        // A host write must not disturb the captured voltages
        wr(`SRB_OFF_RB_GAIN, 16'hffff);
        rd(`SRB_OFF_RB_GAIN, {va, w[7:0]});
        wrap_up();
    end
endmodule : testbench
